// [common/glg_defs.vh]
// glue gate constants: register offsets, field positions, function codes
// assumes a 32-bit apb data path and a 12-bit byte address
`ifndef GLG_DEFS_VH
`define GLG_DEFS_VH

// function codes shared by the vector and reduction gates
`define GLG_OP_AND       2'h0
`define GLG_OP_OR        2'h1
`define GLG_OP_XOR       2'h2
`define GLG_OP_NOT       2'h3

// apb geometry
`define GLG_ADDR_W       12
`define GLG_DATA_W       32

// register byte offsets
`define GLG_REG_CTRL     12'h000
`define GLG_REG_OPA      12'h004
`define GLG_REG_OPB      12'h008
`define GLG_REG_RED_IN   12'h00c
`define GLG_REG_RED_RES  12'h010
`define GLG_REG_VEC_RES  12'h014
`define GLG_REG_CONST    12'h018

// control register fields
`define GLG_CTRL_VOP_LSB 0
`define GLG_CTRL_ROP_LSB 2
`define GLG_CTRL_SRC_BIT 4

// reset values of the software operand registers
`define GLG_RST_OPERAND  32'h0000_0000

`endif

// [design/glg_red_gate.v]
// reduction gate: folds one vector into a single bit
// assumes op is steady from the surrounding logic; purely combinational
`timescale 1ns/1ns
`include "glg_defs.vh"

module glg_red_gate #(
    parameter SIZE = 8
) (
    // function select
    input  wire [1:0]      op,
    // operand
    input  wire [SIZE-1:0] input_vector_a,
    // result
    output reg             result
);

////////////////////////////////////////////////////////////////////////////
// width guard

// a one-input fold is refused: no gate is built and the bit reads low
localparam SIZE_OK = (SIZE >= 2) ? 1'b1 : 1'b0; // RULE6

////////////////////////////////////////////////////////////////////////////
// fold over every bit at once

always @* begin
    result = 1'b0;
    if (SIZE_OK) begin
        case (op)
            `GLG_OP_AND: result = &input_vector_a; // RULE5 RULE7
            `GLG_OP_OR:  result = |input_vector_a; // RULE5 RULE7
            `GLG_OP_XOR: result = ^input_vector_a; // RULE5 RULE7
            // inversion has no reduced form, so it reads as low
            default:     result = 1'b0;
        endcase
    end
end

endmodule // glg_red_gate

// [design/glg_top.v]
// glue gates top: vector gate, reduction gate, constant source, apb view
// assumes core_clk at 250 MHz, apb master on core_clk, operand nets
// from logic in the same design (no synchronisers on the gate path)
// clk_en freezes every flop; the gate path stays live
//
// Behaviour
// RULE1: vector gate applies one chosen and/or/xor/not bit by bit.
// RULE2: vector width is one parameter, any value of one or more.
// RULE3: two-operand modes are n independent two-input gates per bit.
// RULE4: inversion uses only the first operand, one inverter per bit.
// RULE5: reduction gate offers and, or or xor over one vector.
// RULE6: reduction width parameter below two is refused.
// RULE7: reduction gives one bit, the function over all inputs.
// RULE8: constant source drives a fixed tie value or pattern.
// RULE9: by default the constant is one bit wide and high.
// RULE10: constant width and value parameters set the bus and its bits.
// RULE11: constant value may be written decimal, hex or binary alike.
// RULE12: gate and constant paths are combinational, no latency.
`timescale 1ns/1ns
`include "glg_defs.vh"

module glg_top #(
    parameter       VEC_SIZE    = 8,
    parameter       RED_SIZE    = 8,
    parameter [1:0] VEC_OP      = `GLG_OP_AND,
    parameter [1:0] RED_OP      = `GLG_OP_AND,
    parameter       CONST_WIDTH = 1,
    parameter [CONST_WIDTH-1:0] CONST_VALUE = 1'b1 // RULE9 RULE11
) (
    // clock, reset, enable
    input  wire                   core_clk,
    input  wire                   rst_b,
    input  wire                   clk_en,
    // apb slave
    input  wire [`GLG_ADDR_W-1:0] paddr,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`GLG_DATA_W-1:0] pwdata,
    output reg  [`GLG_DATA_W-1:0] prdata,
    output wire                   pready,
    output wire                   pslverr,
    // vector gate nets
    input  wire [VEC_SIZE-1:0]    input_vector_a,
    input  wire [VEC_SIZE-1:0]    input_vector_b,
    output wire [VEC_SIZE-1:0]    vec_result,
    // reduction gate nets
    input  wire [RED_SIZE-1:0]    reduce_in,
    output wire                   red_result,
    // constant source
    output wire [CONST_WIDTH-1:0] const_out
);

////////////////////////////////////////////////////////////////////////////
// address helpers

// only the listed word offsets answer; anything else is an error
function glg_is_mapped;
    input [`GLG_ADDR_W-1:0] a;
    begin
        case (a)
            `GLG_REG_CTRL,
            `GLG_REG_OPA,
            `GLG_REG_OPB,
            `GLG_REG_RED_IN,
            `GLG_REG_RED_RES,
            `GLG_REG_VEC_RES,
            `GLG_REG_CONST: glg_is_mapped = 1'b1;
            default:        glg_is_mapped = 1'b0;
        endcase
    end
endfunction

// write strobe for one register offset
function glg_hit;
    input [`GLG_ADDR_W-1:0] a;
    input [`GLG_ADDR_W-1:0] offset;
    input                   wr;
    begin
        glg_hit = wr && (a == offset);
    end
endfunction

// control word as software reads it back
// unused bits read low
function [`GLG_DATA_W-1:0] glg_ctrl_word;
    input [1:0] vop;
    input [1:0] rop;
    input       src;
    begin
        glg_ctrl_word = {`GLG_DATA_W{1'b0}};
        glg_ctrl_word[`GLG_CTRL_VOP_LSB+1:`GLG_CTRL_VOP_LSB] = vop;
        glg_ctrl_word[`GLG_CTRL_ROP_LSB+1:`GLG_CTRL_ROP_LSB] = rop;
        glg_ctrl_word[`GLG_CTRL_SRC_BIT] = src;
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// apb phase tracking

wire setup_phase;
wire access_phase;
wire write_now;
wire read_setup;
wire addr_bad;

reg  phase_ok;
reg  err_q;

assign setup_phase  = psel & ~penable;
assign access_phase = psel & penable;
assign read_setup   = setup_phase & ~pwrite;
// decoded once at setup; the flop keeps it through wait states
assign addr_bad     = ~glg_is_mapped(paddr);

// pready only after the setup edge was taken, and only while enabled
// clk_en low stretches the access; the master just waits
assign pready    = access_phase & phase_ok & clk_en;
assign pslverr   = pready & err_q;
assign write_now = pready & pwrite & ~err_q;

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        phase_ok <= 1'b0;
        err_q    <= 1'b0;
    end else if (clk_en) begin
        // setup decodes; the pready edge clears for the next transfer
        if (setup_phase) begin
            phase_ok <= 1'b1;
            err_q    <= addr_bad;
        end else if (pready) begin
            phase_ok <= 1'b0;
            err_q    <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// software registers

reg [1:0]             ctrl_vop;
reg [1:0]             ctrl_rop;
reg                   ctrl_src;
reg [`GLG_DATA_W-1:0] reg_opa;
reg [`GLG_DATA_W-1:0] reg_opb;
reg [`GLG_DATA_W-1:0] reg_red_in;

// one strobe per writable register, all from the same qualified write
// read-only offsets match no strobe and are dropped quietly
wire                  wr_ctrl;
wire                  wr_opa;
wire                  wr_opb;
wire                  wr_red_in;

assign wr_ctrl   = glg_hit(paddr, `GLG_REG_CTRL, write_now);
assign wr_opa    = glg_hit(paddr, `GLG_REG_OPA, write_now);
assign wr_opb    = glg_hit(paddr, `GLG_REG_OPB, write_now);
assign wr_red_in = glg_hit(paddr, `GLG_REG_RED_IN, write_now);

// function codes come up at the parameter choices
always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        ctrl_vop   <= VEC_OP;
        ctrl_rop   <= RED_OP;
        ctrl_src   <= 1'b0;
        reg_opa    <= `GLG_RST_OPERAND;
        reg_opb    <= `GLG_RST_OPERAND;
        reg_red_in <= `GLG_RST_OPERAND;
    end else if (clk_en) begin
        if (wr_ctrl) begin
            ctrl_vop <= pwdata[`GLG_CTRL_VOP_LSB+1:`GLG_CTRL_VOP_LSB];
            ctrl_rop <= pwdata[`GLG_CTRL_ROP_LSB+1:`GLG_CTRL_ROP_LSB];
            ctrl_src <= pwdata[`GLG_CTRL_SRC_BIT];
        end
        if (wr_opa) begin
            reg_opa <= pwdata;
        end
        if (wr_opb) begin
            reg_opb <= pwdata;
        end
        if (wr_red_in) begin
            reg_red_in <= pwdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// operand selection

// register operands let software exercise the gates with the pins idle
// zero-extend before slicing so any size works against 32-bit words
wire [VEC_SIZE+31:0] opa_ext;
wire [VEC_SIZE+31:0] opb_ext;
wire [RED_SIZE+31:0] red_ext;

assign opa_ext = {{VEC_SIZE{1'b0}}, reg_opa};
assign opb_ext = {{VEC_SIZE{1'b0}}, reg_opb};
assign red_ext = {{RED_SIZE{1'b0}}, reg_red_in};

wire [VEC_SIZE-1:0] vec_a;
wire [VEC_SIZE-1:0] vec_b;
wire [RED_SIZE-1:0] red_in;

// plain mux, no flop: the pin path keeps zero latency
assign vec_a  = ctrl_src ? opa_ext[VEC_SIZE-1:0] : input_vector_a; // RULE12
assign vec_b  = ctrl_src ? opb_ext[VEC_SIZE-1:0] : input_vector_b; // RULE12
assign red_in = ctrl_src ? red_ext[RED_SIZE-1:0] : reduce_in;      // RULE12

////////////////////////////////////////////////////////////////////////////
// gates

// vector gate: one function for all bits, picked by ctrl_vop
glg_vec_gate #(
    .SIZE           (VEC_SIZE)
) u_vec_gate (
    .op             (ctrl_vop),
    .input_vector_a (vec_a),
    .input_vector_b (vec_b),
    .result         (vec_result)
);

// reduction gate: op code 3 has no fold and reads low
glg_red_gate #(
    .SIZE           (RED_SIZE)
) u_red_gate (
    .op             (ctrl_rop),
    .input_vector_a (red_in),
    .result         (red_result)
);

////////////////////////////////////////////////////////////////////////////
// constant source

// the typed parameter fixes the bit pattern whatever radix was used
// no flop here either: the tie is live during reset
generate
    if (CONST_WIDTH < 1) begin : g_bad_const
        // refused width: a stub bus held low
        assign const_out = {(2-CONST_WIDTH){1'b0}}; // RULE10
    end else begin : g_const
        assign const_out = CONST_VALUE; // RULE8 RULE10 RULE11
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// readback

wire [VEC_SIZE+31:0]    vec_res_ext;
wire [CONST_WIDTH+31:0] const_ext;

assign vec_res_ext = {32'h0000_0000, vec_result};
assign const_ext   = {32'h0000_0000, const_out};

reg [`GLG_DATA_W-1:0] next_prdata;

// read data is taken at the setup edge; results are live at that moment
always @* begin
    next_prdata = 32'h0000_0000;
    case (paddr)
        `GLG_REG_CTRL: begin
            next_prdata = glg_ctrl_word(ctrl_vop, ctrl_rop, ctrl_src);
        end
        `GLG_REG_OPA: begin
            next_prdata = reg_opa;
        end
        `GLG_REG_OPB: begin
            next_prdata = reg_opb;
        end
        `GLG_REG_RED_IN: begin
            next_prdata = reg_red_in;
        end
        `GLG_REG_RED_RES: begin
            next_prdata[0] = red_result;
        end
        `GLG_REG_VEC_RES: begin
            next_prdata = vec_res_ext[31:0];
        end
        `GLG_REG_CONST: begin
            // wide constants show only their low word
            next_prdata = const_ext[31:0];
        end
        // unmapped offsets read zero; pslverr flags them
        default: begin
            next_prdata = 32'h0000_0000;
        end
    endcase
end

always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
        prdata <= 32'h0000_0000;
    end else if (clk_en) begin
        // writes leave prdata at zero; only a read setup loads it
        if (read_setup) begin
            prdata <= next_prdata;
        end else if (pready) begin
            prdata <= 32'h0000_0000;
        end
    end
end

endmodule // glg_top

// [design/glg_vec_gate.v]
// vector gate: one bitwise function over two operand vectors
// assumes op is steady from the surrounding logic; purely combinational
`timescale 1ns/1ns
`include "glg_defs.vh"

module glg_vec_gate #(
    parameter SIZE = 8
) (
    // function select
    input  wire [1:0]      op,
    // operands
    input  wire [SIZE-1:0] input_vector_a,
    input  wire [SIZE-1:0] input_vector_b,
    // result
    output wire [SIZE-1:0] result
);

////////////////////////////////////////////////////////////////////////////
// one bit of the chosen function

function glg_bit_op;
    input [1:0] f;
    input       a;
    input       b;
    begin
        case (f)
            `GLG_OP_AND: glg_bit_op = a & b;
            `GLG_OP_OR:  glg_bit_op = a | b;
            `GLG_OP_XOR: glg_bit_op = a ^ b;
            default:     glg_bit_op = ~a; // RULE4
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// n independent gates, no bit looks at its neighbours

genvar i;
generate
    if (SIZE < 1) begin : g_bad_size
        // refused width: no gates are built, the stub bus reads low
        assign result = {(2-SIZE){1'b0}}; // RULE2
    end
    for (i = 0; i < SIZE; i = i + 1) begin : g_bit
        assign result[i] = glg_bit_op(op, input_vector_a[i],
                                      input_vector_b[i]); // RULE1 RULE3
    end
endgenerate

endmodule // glg_vec_gate

// [testbench/glg_net_model.sv]
// upstream logic model: one flop stage that drives the operand nets
// assumes the bench presents new values one cycle ahead
`timescale 1ns/1ns
module glg_net_model (
    // clock
    input wire logic       core_clk,
    // values to launch
    input wire logic [7:0] a_d, b_d, r_d,
    // operand nets
    output logic     [7:0] vec_a = 8'h00,
    output logic     [7:0] vec_b = 8'h00,
    output logic     [7:0] red_v = 8'h00
);
    always @(posedge core_clk) begin
        vec_a <= a_d;
        vec_b <= b_d;
        red_v <= r_d;
    end
endmodule // glg_net_model

// [testbench/glg_props.sv]
// checker: gate outputs against the chosen function while the pins are the source, with no latency
// assumes binding to glg_top; the control word is mirrored from apb writes
`timescale 1ns/1ns
module glg_props #(
    parameter                   VEC_SIZE    = 8,
    parameter                   RED_SIZE    = 8,
    parameter                   CONST_WIDTH = 1,
    parameter [CONST_WIDTH-1:0] CONST_VALUE = 1'b1
) (
    // clock, reset, apb
    input wire logic                   core_clk, rst_b, psel, penable,
    input wire logic                   pwrite, pready,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    // gate nets
    input wire logic [VEC_SIZE-1:0]    input_vector_a, input_vector_b,
    input wire logic [VEC_SIZE-1:0]    vec_result,
    input wire logic [RED_SIZE-1:0]    reduce_in,
    input wire logic                   red_result,
    input wire logic [CONST_WIDTH-1:0] const_out
);
    logic [4:0] c;
    wire        pin = !c[4];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // mirror resets to the default op codes only
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            c <= 5'h00;
        else if (psel && penable && pready && pwrite && paddr == 12'h000)
            c <= pwdata[4:0];
    end
    ////////////////////////////////////////////////////////////////////////
    property p_and;
        pin && c[1:0] == 2'h0 |-> vec_result == (input_vector_a & input_vector_b);
    endproperty
    a_and: assert property (p_and) else $error("vector and wrong");
    property p_or;
        pin && c[1:0] == 2'h1 |-> vec_result == (input_vector_a | input_vector_b);
    endproperty
    a_or: assert property (p_or) else $error("vector or wrong");
    property p_xor;
        pin && c[1:0] == 2'h2 |-> vec_result == (input_vector_a ^ input_vector_b);
    endproperty
    a_xor: assert property (p_xor) else $error("vector xor wrong");
    property p_not;
        pin && c[1:0] == 2'h3 |-> vec_result == ~input_vector_a;
    endproperty
    a_not: assert property (p_not) else $error("vector not wrong");
    property p_rand;
        pin && c[3:2] == 2'h0 |-> red_result == &reduce_in;
    endproperty
    a_rand: assert property (p_rand) else $error("reduce and wrong");
    property p_ror;
        pin && c[3:2] == 2'h1 |-> red_result == |reduce_in;
    endproperty
    a_ror: assert property (p_ror) else $error("reduce or wrong");
    property p_rxor;
        pin && c[3:2] == 2'h2 |-> red_result == ^reduce_in;
    endproperty
    a_rxor: assert property (p_rxor) else $error("reduce xor wrong");
    property p_const;
        const_out == CONST_VALUE;
    endproperty
    a_const: assert property (p_const) else $error("constant wrong");
    // the vector result may only move when one of its causes moved
    property p_cause;
        pin && $past(pin) && $changed(vec_result) |-> $changed(input_vector_a)
            || $changed(input_vector_b) || $changed(c[1:0]);
    endproperty
    a_cause: assert property (p_cause) else $error("result moved alone");
endmodule // glg_props
bind glg_top glg_props #(.VEC_SIZE(VEC_SIZE), .RED_SIZE(RED_SIZE),
    .CONST_WIDTH(CONST_WIDTH), .CONST_VALUE(CONST_VALUE)) chk_u (.*);

// [testbench/glue_logic_gates_tb_top.sv]
// bench: gate rows through the pins, then apb register cases
// assumes glg_top with a 5-bit constant of 30 and default op codes
`timescale 1ns/1ns
module glue_logic_gates_tb_top;
    logic        core_clk = 0, rst_b = 0, clk_en = 1, psel = 0;
    logic        penable = 0, pwrite = 0, pready, pslverr, red_result, er;
    logic        c_def;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0]  a_d = 8'h00, b_d = 8'h00, r_d = 8'h00, vec_result;
    logic [7:0]  input_vector_a, input_vector_b, reduce_in;
    logic [4:0]  const_out;
    int          err_total = 0, checks_done = 0;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] a, b, r, ev;
        logic       erd;
    } glg_row_t;
    // op, a, b, reduce input, vector result, reduced bit
    glg_row_t rows [6] = '{'{2'h0, 8'hc5, 8'h6a, 8'hff, 8'h40, 1'b1},
        '{2'h0, 8'hff, 8'hff, 8'hfe, 8'hff, 1'b0},
        '{2'h1, 8'hc5, 8'h6a, 8'h00, 8'hef, 1'b0},
        '{2'h1, 8'h00, 8'h00, 8'h80, 8'h00, 1'b1},
        '{2'h2, 8'hc5, 8'h6a, 8'h07, 8'haf, 1'b1},
        '{2'h3, 8'hc5, 8'hff, 8'hff, 8'h3a, 1'b0}};
    glg_net_model net_u (.core_clk(core_clk), .a_d(a_d), .b_d(b_d),
        .r_d(r_d), .vec_a(input_vector_a), .vec_b(input_vector_b),
        .red_v(reduce_in));
    // decimal value on purpose: the bench expects it in hex and binary
    glg_top #(.CONST_WIDTH(5), .CONST_VALUE(5'd30)) dut_u (.*);
    glg_top dut_d (.prdata(), .pready(), .pslverr(), .vec_result(),
        .red_result(), .const_out(c_def), .*);
    initial forever #2 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; waits for pready under a bound
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            report_and_stop;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge core_clk);
        chk("const in reset", const_out, 32'h1e);
        chk("const binary", const_out, {27'h0, 5'b11110});
        chk("default const", c_def, 32'h1);
        rst_b <= 1'b1;
        apb(1'b0, 12'h004, 32'h0);
        chk("opa reset", rd, 32'h0);
        foreach (rows[i]) begin
            apb(1'b1, 12'h000, {28'h0, rows[i].op, rows[i].op});
            a_d <= rows[i].a;
            b_d <= rows[i].b;
            r_d <= rows[i].r;
            // one cycle through the net model, then settled
            repeat (2) @(posedge core_clk);
            chk("vec_result", vec_result, rows[i].ev);
            chk("red_result", red_result, rows[i].erd);
            $display("row %0d done", i);
        end
        apb(1'b0, 12'h018, 32'h0);
        chk("const reg", rd, 32'h1e);
        apb(1'b1, 12'h018, 32'hffffffff);
        apb(1'b0, 12'h018, 32'h0);
        chk("const kept", rd, 32'h1e);
        apb(1'b0, 12'h01c, 32'h0);
        chk("unmapped err", er, 32'h1);
        $display("register cases done");
        // register operands: pins must no longer matter
        apb(1'b1, 12'h004, 32'h5c);
        apb(1'b1, 12'h008, 32'hf0);
        apb(1'b1, 12'h000, 32'h1a);
        @(posedge core_clk);
        chk("reg xor", vec_result, 32'hac);
        apb(1'b0, 12'h014, 32'h0);
        chk("vec reg", rd, 32'hac);
        apb(1'b1, 12'h00c, 32'h0b);
        apb(1'b0, 12'h010, 32'h0);
        chk("red reg", rd, 32'h1);
        chk("red_result src", red_result, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reg", rd, 32'h1a);
        $display("operand source case done");
        // mid-run reset: registers clear, gates keep following the pins
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("vec in reset", vec_result, 32'hc5);
        chk("red in reset", red_result, 32'h1);
        rst_b <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl after reset", rd, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk("opa after reset", rd, 32'h0);
        $display("reset case done");
        report_and_stop;
    end
endmodule // glue_logic_gates_tb_top
